//--- design/pcad_pkg.sv
`default_nettype none

package pcad_pkg;

  // header bit positions
  localparam int CA_RW_BIT    = 47;
  localparam int CA_AS_BIT    = 46;
  localparam int CA_BURST_BIT = 45;
  localparam int CA_ROW_MSB   = 44;
  localparam int CA_ROW_LSB   = 16;
  localparam int CA_COL_MSB   = 2;

  localparam int          HDR_BYTES   = 6;
  localparam logic [2:0]  HDR_ROW_CNT = 3'd3;
  localparam logic [2:0]  HDR_END_CNT = 3'd5;
  localparam int          HALF_PAGE_W = 3;
  localparam int          SYNC_STAGES = 3;

  // link pins as seen by the synchroniser, and their idle levels
  localparam int          LNK_W       = 12;
  localparam logic [11:0] LNK_RST_VAL = 12'hc00;

  // apb register map
  localparam int          APB_AW      = 12;
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STAT    = 12'h004;
  localparam logic [11:0] OFS_ADDR    = 12'h008;

  localparam int          CTRL_W      = 10;
  localparam logic [9:0]  CTRL_RST    = 10'h006;
  localparam int          CTRL_LAT_MSB  = 7;
  localparam int          CTRL_XLAT_BIT = 8;
  localparam int          CTRL_ROWL_BIT = 9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_LAT  = 2'b11,
    ST_DATA = 2'b10
  } pcad_state_type;

endpackage

`default_nettype wire

//--- design/pcad_sync.sv
`default_nettype none

module pcad_sync
  import pcad_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_core_clk,  // core clock
  input  wire logic             i_reset,     // sync reset, active high
  input  wire logic [WIDTH-1:0] i_async,     // pins from outside the domain
  output var  logic [WIDTH-1:0] o_level      // filtered level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage_q;

      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          stage_q <= {SYNC_STAGES{RESET_VAL[g]}};
        end else begin
          stage_q <= {stage_q[SYNC_STAGES-2:0], i_async[g]};
        end
      end

      // only the later two stages vote; a one-stage glitch never counts
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          o_level[g] <= RESET_VAL[g];
        end else if (stage_q[1] == stage_q[2]) begin
          o_level[g] <= stage_q[2];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- design/pcad_decode.sv
// Function
// [R1] header bit 47 high means read, low means write
// [R2] header bit 46 low targets memory array, high targets register space
// [R3] header bit 45 low selects wrapped burst, high selects linear burst
// [R4] header bits 44..16 give word address bits 31..3
// [R5] host zeroes header row bits beyond the memory density
// [R6] header bits 15..3 are reserved and ignored by the memory
// [R7] header bits 2..0 give starting word inside the half-page
// [R8] upper address picks an eight-word half-page, lower picks the word
// [R9] extra strobe latency may be inserted when a burst crosses a row
// [R10] initial access interval starts once row and upper column are captured
// [R11] linear reads run unbroken across consecutive half-pages
// [R12] each address selects one 16-bit word
// [R13] read strobe is driven by memory, data edge-aligned to it
// [R14] transfers are whole words only, never a half word
// [R15] address advances each clock; first byte strobe high, second low
// [R16] byte bit 7 on data line 7 down to bit 0 on line 0
// [R17] first byte carries word bits 15..8, second byte bits 7..0
// [R18] header takes the first three clocks, six edges, double data rate
// [R19] transaction starts when chip select falls with clock idle low
// [R20] memory drives strobe high during header to ask extra latency
// [R21] host drives strobe as byte mask during write data
`default_nettype none

module pcad_decode
  import pcad_pkg::*;
#(
  parameter int          MEM_AW    = 8,
  parameter int          ROW_COL_W = 9,
  parameter logic [15:0] ID_WORD   = 16'h5a3c  // arbitrary value
) (
  input  wire logic              i_core_clk,     // 40 MHz core clock
  input  wire logic              i_reset,        // sync reset, active high
  input  wire logic              i_psel,         // apb select
  input  wire logic              i_penable,      // apb enable
  input  wire logic              i_pwrite,       // apb direction
  input  wire logic [APB_AW-1:0] i_paddr,        // apb byte address
  input  wire logic [31:0]       i_pwdata,       // apb write data
  output var  logic [31:0]       o_prdata,       // apb read data
  output var  logic              o_pready,       // apb ready
  output var  logic              o_pslverr,      // apb error
  input  wire logic              i_link_reset_n, // link hardware reset
  input  wire logic              i_cs_n,         // link chip select
  input  wire logic              i_ck,           // link clock
  input  wire logic [7:0]        i_dq,           // link data in
  input  wire logic              i_read_write_strobe,         // read_write_strobe in
  output var  logic [7:0]        o_dq,           // link data out
  output var  logic              o_dq_oe,        // data drive enable
  output var  logic              o_read_write_strobe,         // read_write_strobe out
  output var  logic              o_read_write_strobe_oe       // strobe drive enable
);

  logic [LNK_W-1:0] lvl;
  logic             lnk_rst_n;
  logic             cs_n_s;
  logic             ck_s;
  logic             read_write_strobe_s;
  logic [7:0]       dq_s;

  pcad_sync #(
    .WIDTH     (LNK_W),
    .RESET_VAL (LNK_RST_VAL)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_link_reset_n, i_cs_n, i_ck, i_read_write_strobe, i_dq}),
    .o_level    (lvl)
  );

  assign lnk_rst_n = lvl[11];
  assign cs_n_s    = lvl[10];
  assign ck_s      = lvl[9];
  assign read_write_strobe_s    = lvl[8];
  assign dq_s      = lvl[7:0];

  // word address from the header; reserved bits never reach it
  function automatic logic [31:0] ca_word_addr(input logic [47:0] h);
    ca_word_addr = {h[CA_ROW_MSB:CA_ROW_LSB], h[CA_COL_MSB:0]}; // [R4] [R6] [R7]
  endfunction

  // wrapped bursts stay inside the eight-word half-page
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic lin);
    if (lin) begin
      next_addr = a + 32'h1; // [R11]
    end else begin
      next_addr = {a[31:HALF_PAGE_W], a[HALF_PAGE_W-1:0] + 3'h1}; // [R8]
    end
  endfunction

  function automatic logic apb_hit(input logic [APB_AW-1:0] a);
    apb_hit = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_ADDR);
  endfunction

  pcad_state_type   st_q;
  logic [2:0]       hdr_cnt_q;
  logic [47:0]      hdr_q;
  logic [47:0]      hdr_next;
  logic             ck_prev_q;
  logic             cs_prev_q;
  logic             ck_rise;
  logic             ck_fall;
  logic             ck_edge;
  logic             soft_rst;
  logic             row_capt;
  logic             hdr_last;
  logic             is_read_q;
  logic             is_reg_q;
  logic             linear_q;
  logic             xlat_q;
  logic [8:0]       lat_cnt_q;
  logic [7:0]       lat_base;
  logic [8:0]       lat_total;
  logic             lat_hit;
  logic             data_rise;
  logic             data_fall;
  logic             a_done_q;
  logic             stall_q;
  logic [31:0]      addr_q;
  logic [15:0]      rd_word;
  logic [15:0]      rd_hold_q;
  logic [7:0]       wr_a_q;
  logic             mask_a_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]      mem [2**MEM_AW];

  // a link reset pin low returns everything link-facing to standby
  assign soft_rst = i_reset | ~lnk_rst_n;

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      ck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      ck_prev_q <= ck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  assign ck_rise  = ck_s & ~ck_prev_q;
  assign ck_fall  = ~ck_s & ck_prev_q;
  assign ck_edge  = ck_rise | ck_fall;
  assign hdr_next = {hdr_q[39:0], dq_s}; // [R16]
  assign row_capt = (st_q == ST_HDR) & ck_edge & (hdr_cnt_q == HDR_ROW_CNT);
  assign hdr_last = (st_q == ST_HDR) & ck_edge & (hdr_cnt_q == HDR_END_CNT);

  // transaction sequencing
  always_ff @(posedge i_core_clk) begin
    if (soft_rst || cs_n_s) begin
      st_q      <= ST_IDLE;
      hdr_cnt_q <= 3'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          hdr_cnt_q <= 3'h0;
          // chip select falling while the clock is high is not a start
          if (cs_prev_q && !ck_s) begin
            st_q <= ST_HDR; // [R19]
          end
        end
        ST_HDR: begin
          if (ck_edge) begin
            hdr_cnt_q <= hdr_cnt_q + 3'h1; // [R18]
          end
          if (hdr_last) begin
            // register writes carry no latency
            if (!hdr_next[CA_RW_BIT] && hdr_next[CA_AS_BIT]) begin
              st_q <= ST_DATA;
            end else begin
              st_q <= ST_LAT;
            end
          end
        end
        ST_LAT: begin
          if (data_rise) begin
            st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          st_q <= ST_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      hdr_q <= 48'h0;
    end else if (st_q == ST_HDR && ck_edge) begin
      hdr_q <= hdr_next; // [R18]
    end
  end

  // transaction attributes
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      is_read_q <= 1'b0;
      is_reg_q  <= 1'b0;
      linear_q  <= 1'b0;
      xlat_q    <= 1'b0;
    end else if (st_q == ST_IDLE && !cs_n_s && cs_prev_q && !ck_s) begin
      xlat_q <= ctrl_q[CTRL_XLAT_BIT]; // [R20]
    end else if (hdr_last) begin
      is_read_q <= hdr_next[CA_RW_BIT]; // [R1]
      is_reg_q  <= hdr_next[CA_AS_BIT]; // [R2]
      linear_q  <= hdr_next[CA_BURST_BIT]; // [R3]
    end
  end

  // latency counts link rises from the moment the row is known
  assign lat_base  = (ctrl_q[CTRL_LAT_MSB:0] == 8'h0) ? 8'h1 : ctrl_q[CTRL_LAT_MSB:0];
  assign lat_total = xlat_q ? {lat_base, 1'b0} : {1'b0, lat_base};
  assign lat_hit   = (lat_cnt_q == lat_total);

  always_ff @(posedge i_core_clk) begin
    if (soft_rst || st_q == ST_IDLE) begin
      lat_cnt_q <= 9'h0;
    end else if (row_capt) begin
      lat_cnt_q <= 9'h0; // [R10]
    end else if (ck_rise && lat_cnt_q != 9'h1ff) begin
      lat_cnt_q <= lat_cnt_q + 9'h1;
    end
  end

  assign data_rise = ck_rise & ~cs_n_s & ((st_q == ST_DATA) | ((st_q == ST_LAT) & lat_hit));
  assign data_fall = ck_fall & ~cs_n_s & (st_q == ST_DATA) & a_done_q;

  // register space content is out of scope; reads return the id word
  assign rd_word = is_reg_q ? ID_WORD : mem[addr_q[MEM_AW-1:0]]; // [R12]

  // word datapath
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      addr_q    <= 32'h0;
      a_done_q  <= 1'b0;
      stall_q   <= 1'b0;
      rd_hold_q <= 16'h0;
      wr_a_q    <= 8'h0;
      mask_a_q  <= 1'b1;
    end else if (hdr_last) begin
      addr_q   <= ca_word_addr(hdr_next);
      a_done_q <= 1'b0;
      stall_q  <= 1'b0;
    end else if (data_rise) begin
      if (stall_q) begin
        stall_q <= 1'b0; // [R9]
      end else begin
        a_done_q  <= 1'b1;
        rd_hold_q <= rd_word;
        wr_a_q    <= dq_s;
        mask_a_q  <= read_write_strobe_s; // [R21]
        if (is_read_q) begin
          addr_q  <= next_addr(addr_q, linear_q); // [R15]
          stall_q <= ctrl_q[CTRL_ROWL_BIT] & linear_q & ~is_reg_q
                     & (&addr_q[ROW_COL_W-1:0]); // [R9]
        end
      end
    end else if (data_fall) begin
      a_done_q <= 1'b0;
      if (!is_read_q) begin
        addr_q <= next_addr(addr_q, linear_q); // [R15]
      end
    end
  end

  // a lone first byte cut off by chip select is dropped, not half-written
  always_ff @(posedge i_core_clk) begin
    if (data_fall && !is_read_q && !is_reg_q) begin // [R14]
      if (!mask_a_q) begin
        mem[addr_q[MEM_AW-1:0]][15:8] <= wr_a_q; // [R17] [R21]
      end
      if (!read_write_strobe_s) begin
        mem[addr_q[MEM_AW-1:0]][7:0] <= dq_s; // [R17] [R21]
      end
    end
  end

  // link pin drivers; outputs lag the sampled edge by the sync stages plus the vote and output registers
  always_ff @(posedge i_core_clk) begin
    if (soft_rst || cs_n_s) begin
      o_dq      <= 8'h0;
      o_dq_oe   <= 1'b0;
      o_read_write_strobe    <= 1'b0;
      o_read_write_strobe_oe <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          o_dq      <= 8'h0;
          o_dq_oe   <= 1'b0;
          o_read_write_strobe    <= 1'b0;
          o_read_write_strobe_oe <= 1'b0;
        end
        ST_HDR: begin
          o_dq_oe   <= 1'b0;
          o_read_write_strobe_oe <= 1'b1;
          o_read_write_strobe    <= xlat_q; // [R20]
        end
        ST_LAT, ST_DATA: begin
          o_read_write_strobe_oe <= is_read_q; // [R13]
          o_dq_oe   <= is_read_q & (a_done_q | data_rise | (st_q == ST_DATA));
          if (!is_read_q) begin
            o_read_write_strobe <= 1'b0;
          end else if (data_rise && !stall_q) begin
            o_dq   <= rd_word[15:8]; // [R13] [R15] [R17]
            o_read_write_strobe <= 1'b1;
          end else if (data_fall) begin
            o_dq   <= rd_hold_q[7:0]; // [R13] [R15] [R17]
            o_read_write_strobe <= 1'b0;
          end else if (st_q == ST_LAT) begin
            o_read_write_strobe <= 1'b0;
          end
        end
      endcase
    end
  end

  // apb slave: one wait state, answer registered
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel && i_penable && !o_pready) begin
        o_pslverr <= ~apb_hit(i_paddr);
        o_prdata  <= 32'h0;
        if (!i_pwrite) begin
          unique case (i_paddr)
            OFS_CTRL: o_prdata <= {{(32-CTRL_W){1'b0}}, ctrl_q};
            OFS_STAT: o_prdata <= {27'h0, (st_q != ST_IDLE), xlat_q,
                                   linear_q, is_reg_q, is_read_q};
            OFS_ADDR: o_prdata <= addr_q;
            default:  o_prdata <= 32'h0;
          endcase
        end
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_q <= CTRL_RST;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFS_CTRL) begin
      ctrl_q <= i_pwdata[CTRL_W-1:0];
    end
  end

endmodule

`default_nettype wire

//--- verification/pcad_asserts.sv
`default_nettype none

module pcad_asserts
  import pcad_pkg::*;
(
  input  wire logic        i_core_clk,     // core clock
  input  wire logic        i_reset,        // sync reset
  input  wire logic        i_psel,         // apb select
  input  wire logic        i_penable,      // apb enable
  input  wire logic [31:0] o_prdata,       // apb read data
  input  wire logic        o_pready,       // apb ready
  input  wire logic        o_pslverr,      // apb error
  input  wire logic        i_link_reset_n, // link reset
  input  wire logic        i_cs_n,         // chip select
  input  wire logic [7:0]  o_dq,           // data out
  input  wire logic        o_dq_oe,        // data enable
  input  wire logic        o_read_write_strobe,         // strobe out
  input  wire logic        o_read_write_strobe_oe       // strobe enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // idle time of chip select, saturating
  logic [3:0] cs_hi_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !i_cs_n) cs_hi_q <= 4'h0;
    else if (cs_hi_q != 4'hf) cs_hi_q <= cs_hi_q + 4'h1;
  end

  AST_PREADY_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready not one cycle after access start");
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_PREADY_CAUSE: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready without access");
  AST_ERR_QUAL: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  AST_DRIVE_PAIR: assert property (o_dq_oe |-> o_read_write_strobe_oe)
    else $error("data driven without strobe");
  AST_IDLE_RELEASE: assert property (cs_hi_q >= 4'h8 |-> !o_dq_oe && !o_read_write_strobe_oe)
    else $error("pins still driven while deselected");
  AST_LINK_RESET: assert property (!i_link_reset_n [*6] |-> !o_dq_oe && !o_read_write_strobe_oe)
    else $error("pins driven during link reset");
  AST_EDGE_ALIGN: assert property (o_dq_oe && $past(o_dq_oe) && o_dq != $past(o_dq)
    |-> o_read_write_strobe != $past(o_read_write_strobe))
    else $error("data changed without strobe edge");
  AST_HDR_STROBE: assert property (o_read_write_strobe_oe && $past(o_read_write_strobe_oe) && !o_dq_oe
    && !$past(o_dq_oe) |-> !$rose(o_read_write_strobe))
    else $error("latency strobe moved before data");
  AST_WHOLE_WORD: assert property ($fell(o_dq_oe) |-> !$past(o_read_write_strobe))
    else $error("read ended inside a word");
endmodule

bind pcad_decode pcad_asserts u_asserts (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_link_reset_n(i_link_reset_n), .i_cs_n(i_cs_n), .o_dq(o_dq),
  .o_dq_oe(o_dq_oe), .o_read_write_strobe(o_read_write_strobe), .o_read_write_strobe_oe(o_read_write_strobe_oe));

`default_nettype wire

//--- verification/pcad_host.sv
`default_nettype none

module pcad_host (
  input  wire logic       i_core_clk, // core clock, for the read monitor
  input  wire logic [7:0] i_dq,       // data wire
  input  wire logic       i_dq_oe,    // device drives data
  input  wire logic       i_strobe,   // strobe wire
  input  wire logic       i_strobe_oe,// device drives strobe
  output var  logic       o_cs_n,     // chip select
  output var  logic       o_ck,       // link clock
  output var  logic [7:0] o_dq,       // host data
  output var  logic       o_strobe    // host strobe, write mask
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] wd [8];
  logic [1:0]  wm [8];
  logic [7:0]  rq [$];
  logic        hdr_strobe;
  logic        prev_strobe = 1'b0;
  logic        prev_oe = 1'b0;
  initial begin
    o_cs_n = 1'b1;
    o_ck = 1'b0;
    o_dq = 8'h00;
    o_strobe = 1'b0;
  end

  // data set half a phase ahead so it is centred on the edge
  task automatic edge_out(input logic [7:0] d, input logic s);
    o_dq = d;
    o_strobe = s;
    #50 o_ck = ~o_ck;
    #50;
  endtask

  // released lines show the inverse of their last value
  task automatic xfer(input logic [47:0] h, input int d0, input int ncyc);
    int k;
    // shift pin changes 5 ns; back-to-back calls add up, so the fifth call in a row lands on a core clock rising edge
    #5;
    o_cs_n = 1'b0;
    #200;
    for (k = 0; k < 6; k++) begin
      edge_out(h[47-8*k -: 8], ~o_strobe);
      if (k == 3) hdr_strobe = i_strobe_oe ? i_strobe : 1'bx;
    end
    for (k = 4; k <= ncyc; k++) begin
      if (k >= d0) begin
        edge_out(wd[k-d0][15:8], wm[k-d0][1]);
        edge_out(wd[k-d0][7:0], wm[k-d0][0]);
      end else begin
        edge_out(~o_dq, ~o_strobe);
        edge_out(~o_dq, ~o_strobe);
      end
    end
    #500 o_cs_n = 1'b1;
    #500;
  endtask

  // a read byte is taken at every strobe change while data is driven
  always @(posedge i_core_clk) begin
    prev_strobe <= i_strobe;
    prev_oe <= i_dq_oe;
    if (i_dq_oe && (i_strobe != prev_strobe || !prev_oe)) rq.push_back(i_dq);
  end
endmodule

`default_nettype wire

//--- verification/tb_psram_cmd_addr_decode.sv
`default_nettype none

module tb_psram_cmd_addr_decode;
  timeunit 1ns;
  timeprecision 100ps;
  import pcad_pkg::*;
  localparam logic [15:0] ID_VAL = 16'h3c5a; // arbitrary value
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;}
    pcad_row_type;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lrst_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, cs_n, ck, dq_oe, st_oe, st_o, h_st, xl;
  logic [7:0] dq_o, h_dq;
  logic [15:0] mem [256], wv [8];
  logic [1:0] wk [8];
  wire  logic [7:0] dq_w = dq_oe ? dq_o : h_dq;
  wire  logic st_w = st_oe ? st_o : h_st;
  int n_errors = 0, n_compared = 0, cyc = 0, lat = 4;
  pcad_row_type rows [9] = '{
    '{1'b0, OFS_CTRL, 32'h0, 32'h006, 1'b0}, '{1'b0, OFS_STAT, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFS_CTRL, 32'hfffffc04, 32'h0, 1'b0}, '{1'b0, OFS_CTRL, 32'h0, 32'h004, 1'b0},
    '{1'b1, OFS_ADDR, 32'h123, 32'h0, 1'b0}, '{1'b0, OFS_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'hffc, 32'h3ff, 32'h0, 1'b1},
    '{1'b0, OFS_CTRL, 32'h0, 32'h004, 1'b0}};

  always #12.5 clk = ~clk;

  pcad_decode #(.ID_WORD(ID_VAL)) dut (.i_core_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_link_reset_n(lrst_n),
    .i_cs_n(cs_n), .i_ck(ck), .i_dq(dq_w), .i_read_write_strobe(st_w), .o_dq(dq_o), .o_dq_oe(dq_oe),
    .o_read_write_strobe(st_o), .o_read_write_strobe_oe(st_oe));
  pcad_host host (.i_core_clk(clk), .i_dq(dq_w), .i_dq_oe(dq_oe), .i_strobe(st_w),
    .i_strobe_oe(st_oe), .o_cs_n(cs_n), .o_ck(ck), .o_dq(h_dq), .o_strobe(h_st));

  task automatic final_report();
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk_bit(1'b0, 1'b1);
  endtask

  // expected memory words come from the bench's own copy of the array; register reads expect ID_VAL
  task automatic link_rw(input logic [47:0] h, input int n);
    logic [31:0] a;
    logic [15:0] e;
    int j;
    a = {h[44:16], h[2:0]};
    host.rq.delete();
    for (j = 0; j < 8; j++) begin
      host.wd[j] = wv[j];
      host.wm[j] = wk[j];
    end
    // first data rise is link cycle lat + 3: the count starts at the fourth edge
    host.xfer(h, h[47] ? 99 : lat + 3, lat + 2 + n);
    chk_bit(host.hdr_strobe, xl);
    if (h[47]) chk_word(host.rq.size(), 2 * n);
    for (j = 0; j < n; j++) begin
      e = h[46] ? ID_VAL : mem[a[7:0]];
      if (!h[47]) begin
        if (!wk[j][1]) mem[a[7:0]][15:8] = wv[j][15:8];
        if (!wk[j][0]) mem[a[7:0]][7:0] = wv[j][7:0];
      end else begin
        chk_word({24'h0, host.rq[2*j]}, {24'h0, e[15:8]});
        chk_word({24'h0, host.rq[2*j+1]}, {24'h0, e[7:0]});
      end
      a = h[45] ? a + 32'h1 : {a[31:3], a[2:0] + 3'd1};
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    xl = 1'b0;
    wv = '{16'ha1b2, 16'hc3d4, 16'he5f6, 16'h0718, 16'h0, 16'h0, 16'h0, 16'h0};
    wk = '{default: 2'b00};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk_bit(er, rows[i].e);
      if (!rows[i].w) chk_word(rd, rows[i].x);
    end
    link_rw({3'b001, 29'd1, 13'h0, 3'd6}, 4);
    wv[0] = 16'h5566;
    wv[1] = 16'h7788;
    link_rw({3'b000, 29'd1, 13'h0, 3'd7}, 2);
    link_rw({3'b101, 29'd1, 13'h1fff, 3'd6}, 4);
    link_rw({3'b100, 29'd1, 13'h0, 3'd7}, 2);
    wv[0] = 16'h99aa;
    wk[0] = 2'b10;
    link_rw({3'b001, 29'd2, 13'h0, 3'd0}, 1);
    wk[0] = 2'b00;
    link_rw({3'b101, 29'd2, 13'h0, 3'd0}, 1);
    link_rw({3'b110, 29'd0, 13'h0, 3'd0}, 2);
    apb(1'b1, OFS_CTRL, 32'h104);
    lat = 8;
    xl = 1'b1;
    link_rw({3'b101, 29'd1, 13'h0, 3'd6}, 2);
    fork
      host.xfer({3'b101, 29'd1, 13'h0, 3'd6}, 99, 8);
      begin
        #500;
        @(posedge clk);
        lrst_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk_bit(st_oe | dq_oe, 1'b0);
        lrst_n <= 1'b1;
      end
    join
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, 32'h104);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, 32'h006);
    final_report();
  end
endmodule

`default_nettype wire
